//--- rtl/fsam_regs.svh
// Opcodes, map sizes, register offsets and field positions of the sector map link
`ifndef FSAM_REGS_SVH
`define FSAM_REGS_SVH

`define FSAM_OP_READ3 8'h03
`define FSAM_OP_READ4 8'h13
`define FSAM_OP_PERASE3 8'h20
`define FSAM_OP_PERASE4 8'h21
`define FSAM_OP_BERASE3 8'hD8
`define FSAM_OP_BERASE4 8'hDC
`define FSAM_OP_AUXRD 8'h4B
`define FSAM_OP_EN4B 8'hB7
`define FSAM_OP_EX4B 8'hE9

`define FSAM_ALEN_NONE 3'h0
`define FSAM_ALEN_3 3'h3
`define FSAM_ALEN_4 3'h4
`define FSAM_ALEN_ONE 3'h1

`define FSAM_SIZE_16MB 32'h0100_0000
`define FSAM_SIZE_32MB 32'h0200_0000
`define FSAM_PSEC_SIZE 32'h0000_1000
`define FSAM_HALF_SIZE 32'h0000_8000
`define FSAM_USEC_SIZE 32'h0001_0000
`define FSAM_LBLK_SIZE 32'h0004_0000
`define FSAM_PSEC_SHIFT 12
`define FSAM_USEC_SHIFT 16
`define FSAM_PSEC_COUNT 10'h008
`define FSAM_SEC_ONE 10'h001
`define FSAM_BYTE_SHIFT 8
`define FSAM_ZERO32 32'h0000_0000

`define FSAM_REG_CTRL 12'h000
`define FSAM_REG_ADDR 12'h004
`define FSAM_REG_CFG 12'h008
`define FSAM_REG_STATUS 12'h00C
`define FSAM_CTRL_OP 7:0
`define FSAM_CTRL_GO 8
`define FSAM_CTRL_AUTO 9
`define FSAM_CFG_EXT_INIT 0
`define FSAM_CFG_TOP 1
`define FSAM_CFG_UNIFORM 2
`define FSAM_CFG_DENS32 3
`define FSAM_CFG_WIDTH 4

`endif

//--- rtl/fsam_pkg.sv
// Types and shared address decoding of the sector map link
package fsam_pkg;
  `include "fsam_regs.svh"

  typedef enum logic [1:0] {FSAM_RSP_OK, FSAM_RSP_REFUSED, FSAM_RSP_ABORT} fsam_rsp_t;
  typedef enum logic [1:0] {FSAM_KIND_READ, FSAM_KIND_ERASE, FSAM_KIND_AUX} fsam_kind_t;
  typedef enum logic [1:0] {FSAM_DS_IDLE, FSAM_DS_ADDR, FSAM_DS_EXEC, FSAM_DS_SKIP} fsam_dstate_t;
  typedef enum logic [1:0] {FSAM_HS_IDLE, FSAM_HS_SEND, FSAM_HS_RESP} fsam_hstate_t;

  // Address bytes that follow an opcode; zero means no address phase
  function automatic logic [2:0] fsam_addr_len(input logic [7:0] op, input logic ext);
    unique case (op)
      `FSAM_OP_READ4, `FSAM_OP_PERASE4, `FSAM_OP_BERASE4: fsam_addr_len = `FSAM_ALEN_4;
      `FSAM_OP_READ3, `FSAM_OP_PERASE3, `FSAM_OP_BERASE3:
        fsam_addr_len = ext ? `FSAM_ALEN_4 : `FSAM_ALEN_3;
      `FSAM_OP_AUXRD: fsam_addr_len = ext ? `FSAM_ALEN_4 : `FSAM_ALEN_3;
      default: fsam_addr_len = `FSAM_ALEN_NONE;
    endcase
  endfunction : fsam_addr_len

  function automatic logic [31:0] fsam_size(input logic dens32);
    fsam_size = dens32 ? `FSAM_SIZE_32MB : `FSAM_SIZE_16MB;
  endfunction : fsam_size

  // Upper address bits beyond the array wrap away; the small part ignores 31..24
  function automatic logic [31:0] fsam_main_addr(input logic [31:0] a, input logic dens32);
    fsam_main_addr = a & (fsam_size(dens32) - 32'h1);
  endfunction : fsam_main_addr

  function automatic logic fsam_in_param(input logic [31:0] m, input logic dens32,
                                         input logic hybrid, input logic top);
    if (top)
      fsam_in_param = hybrid && (m >= fsam_size(dens32) - `FSAM_HALF_SIZE);
    else
      fsam_in_param = hybrid && (m < `FSAM_HALF_SIZE);
  endfunction : fsam_in_param
endpackage : fsam_pkg

//--- rtl/fsam_link_if.sv
// Byte-wide command link between the host controller and the flash map logic
interface fsam_link_if;
  import fsam_pkg::*;
  logic sel;
  logic byte_valid;
  logic [7:0] data;
  logic rsp_valid;
  fsam_rsp_t rsp_code;

  modport ctrl (output sel, output byte_valid, output data, input rsp_valid, input rsp_code);
  modport dev (input sel, input byte_valid, input data, output rsp_valid, output rsp_code);
endinterface : fsam_link_if

//--- rtl/fsam_device.sv
// Flash end: address phase sizing, array masking, sector map and erase steering
//
// The implementer's own choices: the register addresses and the APB register port.
module fsam_device
  import fsam_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  fsam_link_if.dev LINK,
  input wire logic NV_EXT_ADDR,
  input wire logic NV_TOP_PARAM,
  input wire logic DENSITY_32MB,
  input wire logic UNIFORM_MAP,
  input wire logic BLOCK_256K,
  output logic EXT_MODE,
  output logic OP_VALID,
  output fsam_kind_t OP_KIND,
  output logic [31:0] OP_ADDR,
  output logic [31:0] OP_LEN,
  output logic [9:0] OP_SECTOR
);
  `include "fsam_regs.svh"

  fsam_dstate_t state;
  logic [7:0] opcode;
  logic [31:0] addr_sh;
  logic [2:0] left;
  logic ext_mode;
  logic dens32;
  logic top_param;
  logic first_byte;
  logic [2:0] first_len;
  logic hybrid;
  logic [31:0] m;
  logic [31:0] size;
  logic [31:0] unit;
  logic [31:0] base;
  fsam_kind_t next_kind;
  logic [31:0] next_start;
  logic [31:0] next_len;
  fsam_rsp_t next_rsp;

  // Sector index of a main array location in the current map
  function automatic logic [9:0] sector_index(input logic [31:0] a, input logic d32,
                                              input logic hyb, input logic top);
    logic [9:0] u;
    logic [9:0] last;
    logic [31:0] edge_low;
    u = 10'(a >> `FSAM_USEC_SHIFT);
    last = 10'((fsam_size(d32) >> `FSAM_USEC_SHIFT) - 32'h1);
    edge_low = fsam_size(d32) - `FSAM_HALF_SIZE;
    if (!hyb)
      sector_index = u;
    else if (!top) begin
      if (a < `FSAM_HALF_SIZE)
        sector_index = 10'(a >> `FSAM_PSEC_SHIFT);
      else if (u == 10'h000)
        sector_index = `FSAM_PSEC_COUNT;
      else
        sector_index = u + `FSAM_PSEC_COUNT;
    end
    else begin
      if (u < last)
        sector_index = u;
      else if (a < edge_low)
        sector_index = last;
      else
        sector_index = last + `FSAM_SEC_ONE + 10'((a - edge_low) >> `FSAM_PSEC_SHIFT);
    end
  endfunction : sector_index

  assign first_byte = (state == FSAM_DS_IDLE) && LINK.sel && LINK.byte_valid;
  assign first_len = fsam_addr_len(LINK.data, ext_mode);
  assign hybrid = !UNIFORM_MAP;
  assign EXT_MODE = ext_mode;

  // Density and placement are strapped; sampled while reset is held
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      dens32 <= DENSITY_32MB;
      top_param <= NV_TOP_PARAM;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
      ext_mode <= NV_EXT_ADDR;
    else if (first_byte && LINK.data == `FSAM_OP_EN4B)
      ext_mode <= 1'b1;
    else if (first_byte && LINK.data == `FSAM_OP_EX4B)
      ext_mode <= 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      state <= FSAM_DS_IDLE;
      opcode <= 8'h00;
      addr_sh <= `FSAM_ZERO32;
      left <= `FSAM_ALEN_NONE;
    end
    else
    begin
      unique case (state)
        FSAM_DS_IDLE:
          if (first_byte)
          begin
            opcode <= LINK.data;
            addr_sh <= `FSAM_ZERO32;
            left <= first_len;
            state <= (first_len != `FSAM_ALEN_NONE) ? FSAM_DS_ADDR : FSAM_DS_SKIP;
          end
        FSAM_DS_ADDR:
          if (!LINK.sel)
            state <= FSAM_DS_IDLE;
          else if (LINK.byte_valid)
          begin
            addr_sh <= {addr_sh[23:0], LINK.data};
            left <= left - `FSAM_ALEN_ONE;
            if (left == `FSAM_ALEN_ONE)
              state <= FSAM_DS_EXEC;
          end
        FSAM_DS_EXEC:
          state <= FSAM_DS_SKIP;
        FSAM_DS_SKIP:
          // Bytes beyond the address phase are ignored until the frame ends
          if (!LINK.sel)
            state <= FSAM_DS_IDLE;
      endcase
    end
  end

  // Effect of the collected command on the array
  always_comb
  begin
    m = fsam_main_addr(addr_sh, dens32);
    size = fsam_size(dens32);
    unit = BLOCK_256K ? `FSAM_LBLK_SIZE : `FSAM_USEC_SIZE;
    base = m & ~(unit - 32'h1);
    next_kind = FSAM_KIND_READ;
    next_start = m;
    next_len = `FSAM_ZERO32;
    next_rsp = FSAM_RSP_OK;
    unique case (opcode)
      `FSAM_OP_PERASE3, `FSAM_OP_PERASE4:
      begin
        next_kind = FSAM_KIND_ERASE;
        // Outside the parameter group the opcode has nothing to act on
        if (fsam_in_param(m, dens32, hybrid, top_param))
        begin
          next_start = m & ~(`FSAM_PSEC_SIZE - 32'h1);
          next_len = `FSAM_PSEC_SIZE;
        end
        else
          next_rsp = FSAM_RSP_REFUSED;
      end
      `FSAM_OP_BERASE3, `FSAM_OP_BERASE4:
      begin
        next_kind = FSAM_KIND_ERASE;
        next_start = base;
        next_len = unit;
        if (hybrid && !top_param && base == `FSAM_ZERO32)
        begin
          next_start = `FSAM_HALF_SIZE;
          next_len = unit - `FSAM_HALF_SIZE;
        end
        else if (hybrid && top_param && base + unit == size)
          next_len = unit - `FSAM_HALF_SIZE;
      end
      `FSAM_OP_AUXRD:
      begin
        next_kind = FSAM_KIND_AUX;
        next_start = addr_sh;
      end
      default:
      begin
        next_kind = FSAM_KIND_READ;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_code <= FSAM_RSP_OK;
      OP_VALID <= 1'b0;
      OP_KIND <= FSAM_KIND_READ;
      OP_ADDR <= `FSAM_ZERO32;
      OP_LEN <= `FSAM_ZERO32;
      OP_SECTOR <= 10'h000;
    end
    else
    begin
      LINK.rsp_valid <= 1'b0;
      OP_VALID <= 1'b0;
      if (first_byte && first_len == `FSAM_ALEN_NONE)
      begin
        LINK.rsp_valid <= 1'b1;
        if (LINK.data == `FSAM_OP_EN4B || LINK.data == `FSAM_OP_EX4B)
          LINK.rsp_code <= FSAM_RSP_OK;
        else
          LINK.rsp_code <= FSAM_RSP_REFUSED;
      end
      else if (state == FSAM_DS_ADDR && !LINK.sel)
      begin
        // A frame cut short in the address phase leaves the array alone
        LINK.rsp_valid <= 1'b1;
        LINK.rsp_code <= FSAM_RSP_ABORT;
      end
      else if (state == FSAM_DS_EXEC)
      begin
        LINK.rsp_valid <= 1'b1;
        LINK.rsp_code <= next_rsp;
        OP_VALID <= (next_rsp == FSAM_RSP_OK);
        OP_KIND <= next_kind;
        OP_ADDR <= next_start;
        OP_LEN <= next_len;
        OP_SECTOR <= (next_kind == FSAM_KIND_AUX) ? 10'h000 :
                     sector_index(next_start, dens32, hybrid, top_param);
      end
    end
  end
endmodule : fsam_device

//--- rtl/fsam_host.sv
// Host end: APB command registers driving the byte link to the flash map logic
module fsam_host
  import fsam_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  fsam_link_if.ctrl LINK
);
  `include "fsam_regs.svh"

  fsam_hstate_t state;
  logic [7:0] cmd_op;
  logic [31:0] cmd_addr;
  logic [`FSAM_CFG_WIDTH-1:0] cfg;
  logic ext;
  logic got;
  fsam_rsp_t rsp_last;
  logic [7:0] sent_op;
  logic [31:0] shift;
  logic [2:0] left;
  logic mapped;
  logic wr_commit;
  logic go;
  logic busy;
  logic [7:0] go_op;
  logic [2:0] go_len;
  logic [31:0] rd_data;

  assign busy = (state != FSAM_HS_IDLE);
  assign mapped = (PADDR == `FSAM_REG_CTRL) || (PADDR == `FSAM_REG_ADDR) ||
                  (PADDR == `FSAM_REG_CFG) || (PADDR == `FSAM_REG_STATUS);
  assign wr_commit = PSEL && PENABLE && PREADY && PWRITE && mapped;
  // A start while a command is in flight is dropped
  assign go = wr_commit && PADDR == `FSAM_REG_CTRL && PWDATA[`FSAM_CTRL_GO] && !busy;
  // Auto mode steers the erase opcode by the configured map
  assign go_op = !PWDATA[`FSAM_CTRL_AUTO] ? PWDATA[`FSAM_CTRL_OP] :
                 fsam_in_param(fsam_main_addr(cmd_addr, cfg[`FSAM_CFG_DENS32]),
                               cfg[`FSAM_CFG_DENS32], !cfg[`FSAM_CFG_UNIFORM],
                               cfg[`FSAM_CFG_TOP]) ? `FSAM_OP_PERASE4 : `FSAM_OP_BERASE4;
  assign go_len = fsam_addr_len(go_op, ext);

  always_comb
  begin
    rd_data = `FSAM_ZERO32;
    unique case (PADDR)
      `FSAM_REG_CTRL: rd_data = {24'h000000, cmd_op};
      `FSAM_REG_ADDR: rd_data = cmd_addr;
      `FSAM_REG_CFG: rd_data = {28'h0000000, cfg};
      `FSAM_REG_STATUS: rd_data = {28'h0000000, ext, 2'(rsp_last), busy};
      default: rd_data = `FSAM_ZERO32;
    endcase
  end

  // One wait state: ready rises in the first access cycle's edge
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      PREADY <= 1'b0;
      PRDATA <= `FSAM_ZERO32;
      PSLVERR <= 1'b0;
    end
    else if (PSEL && PENABLE && !PREADY)
    begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? `FSAM_ZERO32 : rd_data;
      PSLVERR <= !mapped;
    end
    else
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      cmd_op <= 8'h00;
      cmd_addr <= `FSAM_ZERO32;
      cfg <= '0;
    end
    else if (wr_commit && !busy)
    begin
      if (PADDR == `FSAM_REG_CTRL)
        cmd_op <= go ? go_op : PWDATA[`FSAM_CTRL_OP];
      if (PADDR == `FSAM_REG_ADDR)
        cmd_addr <= PWDATA;
      if (PADDR == `FSAM_REG_CFG)
        cfg <= PWDATA[`FSAM_CFG_WIDTH-1:0];
    end
  end

  // Shadow of the flash's extended mode, seeded by software from the strap
  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
      ext <= 1'b0;
    else if (wr_commit && !busy && PADDR == `FSAM_REG_CFG)
      ext <= PWDATA[`FSAM_CFG_EXT_INIT];
    else if (state == FSAM_HS_RESP && got && rsp_last == FSAM_RSP_OK)
    begin
      if (sent_op == `FSAM_OP_EN4B)
        ext <= 1'b1;
      else if (sent_op == `FSAM_OP_EX4B)
        ext <= 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      got <= 1'b0;
      rsp_last <= FSAM_RSP_OK;
    end
    else if (LINK.rsp_valid)
    begin
      got <= 1'b1;
      rsp_last <= LINK.rsp_code;
    end
    else if (go)
      got <= 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      state <= FSAM_HS_IDLE;
      LINK.sel <= 1'b0;
      LINK.byte_valid <= 1'b0;
      LINK.data <= 8'h00;
      sent_op <= 8'h00;
      shift <= `FSAM_ZERO32;
      left <= `FSAM_ALEN_NONE;
    end
    else
    begin
      unique case (state)
        FSAM_HS_IDLE:
          if (go)
          begin
            LINK.sel <= 1'b1;
            LINK.byte_valid <= 1'b1;
            LINK.data <= go_op;
            sent_op <= go_op;
            left <= go_len;
            // Three-byte phases send the low 24 bits, most significant first
            shift <= (go_len == `FSAM_ALEN_3) ? (cmd_addr << `FSAM_BYTE_SHIFT) : cmd_addr;
            state <= FSAM_HS_SEND;
          end
        FSAM_HS_SEND:
          if (left == `FSAM_ALEN_NONE)
          begin
            LINK.sel <= 1'b0;
            LINK.byte_valid <= 1'b0;
            state <= FSAM_HS_RESP;
          end
          else
          begin
            LINK.data <= shift[31:24];
            shift <= shift << `FSAM_BYTE_SHIFT;
            left <= left - `FSAM_ALEN_ONE;
          end
        FSAM_HS_RESP:
          if (got)
            state <= FSAM_HS_IDLE;
        // The fourth code of the state word is never entered; fall back to idle
        default:
          state <= FSAM_HS_IDLE;
      endcase
    end
  end
endmodule : fsam_host

//--- verification/fsam_link_assertions.sv
// Protocol checks on the byte link between the host and flash ends
module fsam_link_assertions
  import fsam_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic sel,
  input wire logic byte_valid,
  input wire logic [7:0] data,
  input wire logic rsp_valid,
  input wire fsam_rsp_t rsp_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [7:0] op;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // Saturates so a run of stray bytes cannot wrap back to a legal count
  always_ff @(posedge MCLK)
  begin
    if (!RST_B || !sel)
      cnt <= 4'h0;
    else if (byte_valid && cnt != 4'hF)
      cnt <= cnt + 4'h1;
  end
  always_ff @(posedge MCLK)
  begin
    if (sel && byte_valid && cnt == 4'h0)
      op <= data;
  end
  sequence frame_end;
    $fell(sel);
  endsequence
  sequence opcode_byte;
    sel && byte_valid && cnt == 4'h0;
  endsequence
  four_byte_a: assert property (frame_end ##0 op inside {8'h13, 8'h21, 8'hDC} |-> cnt == 4'h5)
    else $error("dedicated opcode sent with wrong address length");
  legacy_len_a: assert property (frame_end ##0 op inside {8'h03, 8'h20, 8'hD8, 8'h4B}
    |-> cnt == 4'h4 || cnt == 4'h5) else $error("legacy opcode sent with wrong address length");
  mode_len_a: assert property (frame_end ##0 op inside {8'hB7, 8'hE9} |-> cnt == 4'h1)
    else $error("mode opcode carried address bytes");
  answer_time_a: assert property (frame_end ##0 cnt >= 4'h4 |=> rsp_valid)
    else $error("answer not one cycle after frame end");
  mode_answer_a: assert property (opcode_byte ##0 data inside {8'hB7, 8'hE9}
    |=> rsp_valid && rsp_code == FSAM_RSP_OK) else $error("mode change not answered");
  single_rsp_a: assert property (rsp_valid |=> !rsp_valid [*2])
    else $error("answer pulse repeated");
  strobe_sel_a: assert property (byte_valid |-> sel)
    else $error("byte strobe outside frame");
  frame_gap_a: assert property (frame_end |=> !sel)
    else $error("no idle cycle between frames");
endmodule : fsam_link_assertions

//--- verification/tb.sv
// Self-checking bench: host and flash ends joined over the byte link
module tb;
  import fsam_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, OP_ADDR, OP_LEN, rv;
  logic PREADY, PSLVERR, EXT_MODE, OP_VALID, re, ext, op2;
  int rsp_n = 0;
  int op_n = 0;
  logic nv_ext = 1'b0, nv_top = 1'b0, dens = 1'b0, unif = 1'b0, b256 = 1'b0;
  fsam_kind_t OP_KIND;
  fsam_rsp_t cap;
  logic [9:0] OP_SECTOR;
  int errors = 0;
  int check_count = 0;
  wire [31:0] sz = dens ? 32'h0200_0000 : 32'h0100_0000;
  fsam_link_if lk();
  fsam_link_if lk2();
  always #5 MCLK = ~MCLK;
  fsam_host i_fsam_host (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .LINK(lk));
  fsam_device i_fsam_device (.MCLK(MCLK), .RST_B(RST_B), .LINK(lk), .NV_EXT_ADDR(nv_ext),
    .NV_TOP_PARAM(nv_top), .DENSITY_32MB(dens), .UNIFORM_MAP(unif), .BLOCK_256K(b256),
    .EXT_MODE(EXT_MODE), .OP_VALID(OP_VALID), .OP_KIND(OP_KIND), .OP_ADDR(OP_ADDR),
    .OP_LEN(OP_LEN), .OP_SECTOR(OP_SECTOR));
  // Second flash end driven straight from the bench to cut a frame short
  fsam_device i_fsam_device_2 (.MCLK(MCLK), .RST_B(RST_B), .LINK(lk2), .NV_EXT_ADDR(nv_ext),
    .NV_TOP_PARAM(nv_top), .DENSITY_32MB(dens), .UNIFORM_MAP(unif), .BLOCK_256K(b256),
    .EXT_MODE(), .OP_VALID(op2), .OP_KIND(), .OP_ADDR(), .OP_LEN(), .OP_SECTOR());
  fsam_link_assertions i_chk (.MCLK(MCLK), .RST_B(RST_B), .sel(lk.sel),
    .byte_valid(lk.byte_valid), .data(lk.data), .rsp_valid(lk.rsp_valid),
    .rsp_code(lk.rsp_code));
  // Pulses are counted, so a doubled answer shows up as well as a missing one
  always @(posedge MCLK)
  begin
    if (lk.rsp_valid)
      rsp_n <= rsp_n + 1;
    if (lk.rsp_valid)
      cap <= lk.rsp_code;
    if (OP_VALID)
      op_n <= op_n + 1;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rsp(input fsam_rsp_t got, input fsam_rsp_t exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rsp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    rv = PRDATA;
    re = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1)
    begin
      errors++;
      test_done();
    end
    // An idle edge keeps the next setup from driving the select again in this time step
    @(posedge MCLK);
  endtask : apb
  function automatic logic inpar(input logic [31:0] x);
    logic [31:0] m;
    m = x & (sz - 32'h1);
    return !unif && (nv_top ? m >= sz - 32'h8000 : m < 32'h8000);
  endfunction : inpar
  function automatic logic [31:0] sec_of(input logic [31:0] x);
    logic [31:0] last;
    last = (sz >> 16) - 32'h1;
    if (unif || (nv_top && (x >> 16) < last))
      return x >> 16;
    if (nv_top)
      return x[15] ? last + 32'h1 + 32'(x[14:12]) : last;
    if (x < 32'h8000)
      return x >> 12;
    return x < 32'h0001_0000 ? 32'h8 : (x >> 16) + 32'h8;
  endfunction : sec_of
  // Opcode 00h stands for the host's automatic choice of erase opcode
  task automatic cmd(input logic [7:0] op, input logic [31:0] a);
    logic [31:0] m, u, st, ln;
    logic ev;
    fsam_kind_t ek;
    fsam_rsp_t er;
    int n;
    int r0;
    int o0;
    r0 = rsp_n;
    o0 = op_n;
    apb(1'b1, 12'h004, a);
    apb(1'b1, 12'h000, {22'h0, op == 8'h00, 1'b1, op});
    n = 0;
    do
    begin
      apb(1'b0, 12'h00C, 32'h0);
      n++;
    end
    while (rv[0] !== 1'b0 && n < 30);
    chk(32'(n < 30), 32'h1);
    if (rv[0] !== 1'b0)
      test_done();
    if (op == 8'h00)
      op = inpar(a) ? 8'h21 : 8'hDC;
    if (!(op inside {8'h13, 8'h21, 8'hDC}) && !ext)
      a[31:24] = 8'h00;
    m = a & (sz - 32'h1);
    u = b256 ? 32'h0004_0000 : 32'h0001_0000;
    ek = FSAM_KIND_ERASE;
    if (op inside {8'h03, 8'h13})
      ek = FSAM_KIND_READ;
    if (op == 8'h4B)
      ek = FSAM_KIND_AUX;
    ev = op inside {8'h03, 8'h13, 8'h4B, 8'h20, 8'h21, 8'hD8, 8'hDC};
    er = FSAM_RSP_OK;
    if ((!ev && !(op inside {8'hB7, 8'hE9})) || (op inside {8'h20, 8'h21} && !inpar(m)))
      er = FSAM_RSP_REFUSED;
    ev = ev && er == FSAM_RSP_OK;
    st = ek == FSAM_KIND_READ ? m : (ek == FSAM_KIND_AUX ? a : {m[31:12], 12'h000});
    ln = ek == FSAM_KIND_ERASE ? 32'h1000 : 32'h0;
    if (op inside {8'hD8, 8'hDC})
    begin
      st = m & ~(u - 32'h1);
      ln = (!unif && st == (nv_top ? sz - u : 32'h0)) ? u - 32'h8000 : u;
      st = (!unif && !nv_top && st == 32'h0) ? 32'h8000 : st;
    end
    if (op == 8'hB7 || op == 8'hE9)
      ext = op == 8'hB7;
    chk(32'(rsp_n - r0), 32'h1);
    chk_rsp(cap, er);
    chk(32'(op_n - o0), 32'(ev));
    if (ev)
    begin
      chk(32'(OP_KIND), 32'(ek));
      chk(OP_ADDR, st);
      chk(OP_LEN, ln);
      chk(32'(OP_SECTOR), ek == FSAM_KIND_AUX ? 32'h0 : sec_of(st));
    end
    chk(32'(EXT_MODE), 32'(ext));
    chk(32'(rv[3:1]), 32'({ext, er}));
  endtask : cmd
  initial
  begin
    logic [31:0] r;
    logic [7:0] ops [14];
    int n;
    ops = '{8'h03, 8'h20, 8'hD8, 8'h4B, 8'hB7, 8'h03, 8'h20, 8'hD8, 8'h13, 8'h21, 8'hDC,
            8'hE9, 8'h77, 8'h00};
    lk2.sel = 1'b0;
    lk2.byte_valid = 1'b0;
    lk2.data = 8'h00;
    void'($urandom(28847));
    for (int k = 0; k < 8; k++)
    begin
      RST_B <= 1'b0;
      nv_ext <= k[0];
      nv_top <= k[1];
      dens <= k[2];
      repeat (4) @(posedge MCLK);
      RST_B <= 1'b1;
      @(posedge MCLK);
      ext = k[0];
      chk(32'(EXT_MODE), 32'(ext));
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, re}, 32'h1);
      chk(rv, 32'h0);
      for (int j = 0; j < 4; j++)
      begin
        unif <= j[0];
        b256 <= j[1];
        @(posedge MCLK);
        apb(1'b1, 12'h008, {28'h0, dens, unif, nv_top, ext});
        apb(1'b0, 12'h008, 32'h0);
        chk(rv, {28'h0, dens, unif, nv_top, ext});
        foreach (ops[i])
        begin
          r = $urandom;
          cmd(ops[i], r);
          cmd(ops[i], r & 32'h7FFF);
          cmd(ops[i], 32'h01FF_8000 | (r & 32'h7FFF));
          cmd(ops[i], 32'h0000_8000 | (r & 32'h7FFF));
          cmd(ops[i], 32'h00FF_0000 | (r & 32'hFFFF));
        end
        // The last command was an automatic erase: address and chosen opcode read back
        apb(1'b0, 12'h004, 32'h0);
        chk(rv, 32'h00FF_0000 | (r & 32'hFFFF));
        apb(1'b0, 12'h000, 32'h0);
        chk(rv, {24'h0, (inpar(32'h00FF_0000 | (r & 32'hFFFF)) ? 8'h21 : 8'hDC)});
      end
      $display("map test with straps %0d done", k);
    end
    lk2.sel <= 1'b1;
    lk2.byte_valid <= 1'b1;
    lk2.data <= 8'h03;
    @(posedge MCLK);
    lk2.data <= 8'h12;
    @(posedge MCLK);
    lk2.sel <= 1'b0;
    lk2.byte_valid <= 1'b0;
    n = 0;
    while (lk2.rsp_valid !== 1'b1 && n < 5)
    begin
      @(posedge MCLK);
      n++;
    end
    chk(32'(n), 32'h2);
    chk_rsp(lk2.rsp_code, FSAM_RSP_ABORT);
    chk(32'(op2), 32'h0);
    $display("short frame test done");
    test_done();
  end
endmodule : tb
